// ==== switch_queue_vlan_entry_map.svh ====
// offsets, field positions, codes and reset values of the queue control and vlan entry word zero registers
// assumes byte addressing on a 16-bit register address, one aligned 32-bit word per register
//
// Operation
// - two-queue mapping field applies only while two-queue egress mode is selected
// - map code 00: priorities 0-2 low queue, 3 high; code 01 unused
// - map code 10, reset value: priorities 0-1 low queue, 2-3 high
// - map code 11: priority 0 low queue, priorities 1-3 high
// - discard bit set, reset value: every frame limited to ingress forwarding ports
// - discard bit clear: single-destination frames not limited to ingress forwarding ports
// - discard bit clear, mirroring on: mirrored single-destination frame is dropped
// - entry bit 31 is the valid flag, reset zero
// - forward override bit 27 set on a valid entry: forward to the entry's own egress port map
// - forward override clear: ports come from lookup, vlan or unknown handling
// - entry holds 3-bit priority in bits 26:24, reset zero
// - entry holds 3-bit spanning tree instance in bits 14:12, reset zero
// - entry holds 7-bit filter identifier in bits 6:0 for lookup hashing
// - egress port map bits 6:0 are ports 7:1, bit 4 reserved
`ifndef SWITCH_QUEUE_VLAN_ENTRY_MAP_SVH
`define SWITCH_QUEUE_VLAN_ENTRY_MAP_SVH

`define QUEUE_CTRL_OFFSET     16'h0390
`define VLAN_ENTRY0_OFFSET    16'h0400

`define TQ_MAP_MSB            7
`define TQ_MAP_LSB            6
`define QRSV_MSB              5
`define QRSV_LSB              2
`define UCAST_DISCARD_BIT     1
`define QRSV0_BIT             0

`define ENTRY_VALID_BIT       31
`define ENTRY_FWD_OVR_BIT     27
`define ENTRY_PRIO_MSB        26
`define ENTRY_PRIO_LSB        24
`define ENTRY_STI_MSB         14
`define ENTRY_STI_LSB         12
`define ENTRY_FILTER_MSB      6
`define ENTRY_FILTER_LSB      0

`define TQ_MAP_RESET          2'h2
`define QRSV_RESET            4'h0
`define UCAST_DISCARD_RESET   1'h1
`define QRSV0_RESET           1'h0
`define ENTRY_VALID_RESET     1'h0
`define ENTRY_FWD_OVR_RESET   1'h0
`define ENTRY_PRIO_RESET      3'h0
`define ENTRY_STI_RESET       3'h0
`define ENTRY_FILTER_RESET    7'h00

`define TQ_CODE_THREE_LOW     2'h0
`define TQ_CODE_UNUSED        2'h1
`define TQ_CODE_TWO_LOW       2'h2
`define TQ_CODE_ONE_LOW       2'h3

`define QUEUE_LOW             2'h0
`define QUEUE_HIGH            2'h1

`define PORT_RESERVED_BIT     4

`endif

// ==== switch_queue_vlan_entry_pkg.sv ====
// types shared by the queue control and vlan entry register bank
// assumes the map header is included by the modules that need offsets
package switch_queue_vlan_entry_pkg;

	typedef logic [6:0] port_map_t;

	typedef struct packed {
		logic [1:0] two_queue_priority_map;
		logic [3:0] reserved_rw;
		logic       unicast_membership_discard;
		logic       reserved_rw0;
	} queue_ctrl_t;

	typedef struct packed {
		logic       entry_valid;
		logic       entry_forward_override;
		logic [2:0] vlan_priority;
		logic [2:0] spanning_tree_instance;
		logic [6:0] filter_identifier;
	} vlan_entry_t;

	typedef struct packed {
		port_map_t ingress_member_map;
		port_map_t other_source_map;
		port_map_t vlan_forward_map;
		logic      single_destination;
		logic      mirrored;
	} frame_req_t;

	typedef struct packed {
		port_map_t forward_map;
		logic      dropped;
	} fwd_result_t;

endpackage

// ==== two_queue_mapper.sv ====
// maps a 2-bit regenerated priority onto a low or high egress queue in two-queue mode, else passes it through
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ns
`include "switch_queue_vlan_entry_map.svh"
module two_queue_mapper (
	input  wire logic [1:0] i_map_code,
	input  wire logic       i_two_queue_mode,
	input  wire logic [1:0] i_priority,
	output logic      [1:0] o_queue
);

	////////////////////////////////////////////////////////////////////////////////
	// decode of the mapping code into a high-queue decision
	function automatic logic goes_high(input logic [1:0] code, input logic [1:0] prio);
		logic high;
		high = 1'b0;
		case (code)
			`TQ_CODE_THREE_LOW: high = (prio == 2'h3);
			`TQ_CODE_TWO_LOW:   high = (prio >= 2'h2);
			`TQ_CODE_ONE_LOW:   high = (prio >= 2'h1);
			`TQ_CODE_UNUSED:    high = (prio >= 2'h2);
			default:            high = (prio >= 2'h2);
		endcase
		return high;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// four-queue mode passes the priority through unchanged
	always_comb begin
		if (i_two_queue_mode) begin
			o_queue = goes_high(i_map_code, i_priority) ? `QUEUE_HIGH : `QUEUE_LOW;
		end else begin
			o_queue = i_priority;
		end
	end

endmodule

// ==== switch_queue_vlan_entry_regs.sv ====
// queue management control and vlan entry word zero registers with their datapath use
// assumes a single-cycle strobe register port and synchronous side-band frame requests
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "switch_queue_vlan_entry_map.svh"
module switch_queue_vlan_entry_regs (
	input  wire logic                                   i_clock,
	input  wire logic                                   i_arst_n,
	input  wire logic [15:0]                            i_reg_addr,
	input  wire logic [31:0]                            i_reg_wr_data,
	input  wire logic                                   i_reg_wr_en,
	input  wire logic                                   i_reg_rd_en,
	output logic      [31:0]                            o_reg_rd_data,
	input  wire logic                                   i_two_queue_mode,
	input  wire logic                                   i_queue_req_valid,
	input  wire logic [1:0]                             i_regen_priority,
	output logic                                        o_queue_valid,
	output logic      [1:0]                             o_queue_select,
	input  wire logic                                   i_mirror_enable,
	input  wire logic                                   i_frame_valid,
	input  wire switch_queue_vlan_entry_pkg::frame_req_t i_frame,
	output logic                                        o_fwd_valid,
	output switch_queue_vlan_entry_pkg::fwd_result_t    o_fwd,
	output switch_queue_vlan_entry_pkg::vlan_entry_t    o_entry,
	output switch_queue_vlan_entry_pkg::queue_ctrl_t    o_queue_ctrl
);

	import switch_queue_vlan_entry_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// register state

	queue_ctrl_t  queue_ctrl_ff;
	vlan_entry_t  entry_ff;
	logic [31:0]  rd_data_ff;

	logic         queue_valid_ff;
	logic [1:0]   queue_select_ff;

	logic         fwd_valid_ff;
	fwd_result_t  fwd_ff;

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	logic         hit_queue_ctrl;
	logic         hit_entry;
	logic         wr_queue_ctrl;
	logic         wr_entry;
	logic         rd_queue_ctrl;
	logic         rd_entry;
	logic [31:0]  nxt_rd_data;

	// one word per register, so only an exact match selects it
	function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] offset);
		return (addr == offset);
	endfunction

	assign hit_queue_ctrl = addr_hit(i_reg_addr, `QUEUE_CTRL_OFFSET);
	assign hit_entry      = addr_hit(i_reg_addr, `VLAN_ENTRY0_OFFSET);
	assign wr_queue_ctrl  = i_reg_wr_en & hit_queue_ctrl;
	assign wr_entry       = i_reg_wr_en & hit_entry;
	assign rd_queue_ctrl  = i_reg_rd_en & hit_queue_ctrl;
	assign rd_entry       = i_reg_rd_en & hit_entry;

	////////////////////////////////////////////////////////////////////////////////
	// packing of register images, read-only reserved bits held at zero

	function automatic logic [31:0] pack_queue_ctrl(input queue_ctrl_t q);
		logic [31:0] word;
		word = 32'h0000_0000;
		word[`TQ_MAP_MSB:`TQ_MAP_LSB] = q.two_queue_priority_map;
		word[`QRSV_MSB:`QRSV_LSB]     = q.reserved_rw;
		word[`UCAST_DISCARD_BIT]      = q.unicast_membership_discard;
		word[`QRSV0_BIT]              = q.reserved_rw0;
		return word;
	endfunction

	function automatic logic [31:0] pack_entry(input vlan_entry_t e);
		logic [31:0] word;
		word = 32'h0000_0000;
		word[`ENTRY_VALID_BIT]                   = e.entry_valid;
		word[`ENTRY_FWD_OVR_BIT]                 = e.entry_forward_override;
		word[`ENTRY_PRIO_MSB:`ENTRY_PRIO_LSB]    = e.vlan_priority;
		word[`ENTRY_STI_MSB:`ENTRY_STI_LSB]      = e.spanning_tree_instance;
		word[`ENTRY_FILTER_MSB:`ENTRY_FILTER_LSB] = e.filter_identifier;
		return word;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register images as software reads them

	logic [31:0]  queue_ctrl_image;
	logic [31:0]  entry_image;

	assign queue_ctrl_image = pack_queue_ctrl(queue_ctrl_ff);
	assign entry_image      = pack_entry(entry_ff);

	////////////////////////////////////////////////////////////////////////////////
	// next register values; only the writable ranges of the write word are taken

	queue_ctrl_t  nxt_queue_ctrl;
	vlan_entry_t  nxt_entry;

	always_comb begin
		nxt_queue_ctrl = queue_ctrl_ff;
		if (wr_queue_ctrl) begin
			nxt_queue_ctrl.two_queue_priority_map     = i_reg_wr_data[`TQ_MAP_MSB:`TQ_MAP_LSB];
			nxt_queue_ctrl.reserved_rw                = i_reg_wr_data[`QRSV_MSB:`QRSV_LSB];
			nxt_queue_ctrl.unicast_membership_discard = i_reg_wr_data[`UCAST_DISCARD_BIT];
			nxt_queue_ctrl.reserved_rw0               = i_reg_wr_data[`QRSV0_BIT];
		end
	end

	always_comb begin
		nxt_entry = entry_ff;
		if (wr_entry) begin
			nxt_entry.entry_valid            = i_reg_wr_data[`ENTRY_VALID_BIT];
			nxt_entry.entry_forward_override = i_reg_wr_data[`ENTRY_FWD_OVR_BIT];
			nxt_entry.vlan_priority          = i_reg_wr_data[`ENTRY_PRIO_MSB:`ENTRY_PRIO_LSB];
			nxt_entry.spanning_tree_instance = i_reg_wr_data[`ENTRY_STI_MSB:`ENTRY_STI_LSB];
			nxt_entry.filter_identifier      = i_reg_wr_data[`ENTRY_FILTER_MSB:`ENTRY_FILTER_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// queue management control writes

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			queue_ctrl_ff.two_queue_priority_map <= `TQ_MAP_RESET;
		end else if (wr_queue_ctrl) begin
			queue_ctrl_ff.two_queue_priority_map <= nxt_queue_ctrl.two_queue_priority_map;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			queue_ctrl_ff.reserved_rw  <= `QRSV_RESET;
			queue_ctrl_ff.reserved_rw0 <= `QRSV0_RESET;
		end else if (wr_queue_ctrl) begin
			queue_ctrl_ff.reserved_rw  <= nxt_queue_ctrl.reserved_rw;
			queue_ctrl_ff.reserved_rw0 <= nxt_queue_ctrl.reserved_rw0;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			queue_ctrl_ff.unicast_membership_discard <= `UCAST_DISCARD_RESET;
		end else if (wr_queue_ctrl) begin
			queue_ctrl_ff.unicast_membership_discard <= nxt_queue_ctrl.unicast_membership_discard;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// vlan entry word zero writes, reserved ranges dropped

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			entry_ff.entry_valid <= `ENTRY_VALID_RESET;
		end else if (wr_entry) begin
			entry_ff.entry_valid <= nxt_entry.entry_valid;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			entry_ff.entry_forward_override <= `ENTRY_FWD_OVR_RESET;
		end else if (wr_entry) begin
			entry_ff.entry_forward_override <= nxt_entry.entry_forward_override;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			entry_ff.vlan_priority <= `ENTRY_PRIO_RESET;
		end else if (wr_entry) begin
			entry_ff.vlan_priority <= nxt_entry.vlan_priority;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			entry_ff.spanning_tree_instance <= `ENTRY_STI_RESET;
		end else if (wr_entry) begin
			entry_ff.spanning_tree_instance <= nxt_entry.spanning_tree_instance;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			entry_ff.filter_identifier <= `ENTRY_FILTER_RESET;
		end else if (wr_entry) begin
			entry_ff.filter_identifier <= nxt_entry.filter_identifier;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port: data stands only in the cycle after the strobe

	always_comb begin
		nxt_rd_data = 32'h0000_0000;
		if (rd_queue_ctrl) begin
			nxt_rd_data = queue_ctrl_image;
		end else if (rd_entry) begin
			nxt_rd_data = entry_image;
		end else begin
			nxt_rd_data = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_data_ff <= 32'h0000_0000;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// queue request fields

	logic         queue_take;
	logic         queue_two_mode;
	logic [1:0]   queue_priority;

	assign queue_take     = i_queue_req_valid;
	assign queue_two_mode = i_two_queue_mode;
	assign queue_priority = i_regen_priority;

	////////////////////////////////////////////////////////////////////////////////
	// egress queue selection

	logic [1:0]   nxt_queue_select;

	two_queue_mapper u_two_queue_mapper (
		.i_map_code       (queue_ctrl_ff.two_queue_priority_map),
		.i_two_queue_mode (queue_two_mode),
		.i_priority       (queue_priority),
		.o_queue          (nxt_queue_select)
	);

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			queue_valid_ff <= 1'b0;
		end else begin
			queue_valid_ff <= queue_take;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			queue_select_ff <= `QUEUE_LOW;
		end else if (queue_take) begin
			queue_select_ff <= nxt_queue_select;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame request fields

	logic         frame_take;
	port_map_t    ingress_map;
	port_map_t    other_map;
	port_map_t    vlan_map;
	logic         single_dest;
	logic         mirrored_frame;

	assign frame_take     = i_frame_valid;
	assign ingress_map    = i_frame.ingress_member_map;
	assign other_map      = i_frame.other_source_map;
	assign vlan_map       = i_frame.vlan_forward_map;
	assign single_dest    = i_frame.single_destination;
	assign mirrored_frame = i_frame.mirrored;

	////////////////////////////////////////////////////////////////////////////////
	// forwarding port resolution

	logic         use_entry_map;
	logic         restrict_to_member;
	logic         mirror_drop;
	port_map_t    candidate_map;
	port_map_t    member_mask;
	port_map_t    nxt_forward_map;

	// an invalid staged entry never overrides the other sources
	assign use_entry_map = entry_ff.entry_valid & entry_ff.entry_forward_override;

	// multi-destination frames stay limited even with the discard bit clear
	assign restrict_to_member = queue_ctrl_ff.unicast_membership_discard | ~single_dest;

	assign mirror_drop = ~queue_ctrl_ff.unicast_membership_discard & single_dest
		& i_mirror_enable & mirrored_frame;

	genvar port_idx;
	generate
		for (port_idx = 0; port_idx < 7; port_idx = port_idx + 1) begin : g_port
			if (port_idx == `PORT_RESERVED_BIT) begin : g_reserved
				assign candidate_map[port_idx]   = 1'b0;
				assign member_mask[port_idx]     = 1'b0;
				assign nxt_forward_map[port_idx] = 1'b0;
			end else begin : g_used
				assign candidate_map[port_idx] = use_entry_map ? vlan_map[port_idx]
					: other_map[port_idx];
				assign member_mask[port_idx] = ~restrict_to_member | ingress_map[port_idx];
				assign nxt_forward_map[port_idx] = candidate_map[port_idx] & member_mask[port_idx] & ~mirror_drop;
			end
		end
	endgenerate

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fwd_valid_ff <= 1'b0;
		end else begin
			fwd_valid_ff <= frame_take;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fwd_ff.forward_map <= 7'h00;
		end else if (frame_take) begin
			fwd_ff.forward_map <= nxt_forward_map;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fwd_ff.dropped <= 1'b0;
		end else if (frame_take) begin
			fwd_ff.dropped <= mirror_drop;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops

	assign o_reg_rd_data  = rd_data_ff;
	assign o_queue_valid  = queue_valid_ff;
	assign o_queue_select = queue_select_ff;
	assign o_fwd_valid    = fwd_valid_ff;
	assign o_fwd          = fwd_ff;
	assign o_entry        = entry_ff;
	assign o_queue_ctrl   = queue_ctrl_ff;

endmodule

// ==== switch_queue_vlan_entry_regs_monitor.sv ====
// assertions on the queue control and vlan entry register bank ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ns
`include "switch_queue_vlan_entry_map.svh"
module switch_queue_vlan_entry_regs_monitor (
	input wire logic                                   i_clock,
	input wire logic                                   i_arst_n,
	input wire logic [15:0]                            i_reg_addr,
	input wire logic                                   i_reg_rd_en,
	input wire logic [31:0]                            o_reg_rd_data,
	input wire logic                                   i_two_queue_mode,
	input wire logic                                   i_queue_req_valid,
	input wire logic [1:0]                             i_regen_priority,
	input wire logic                                   o_queue_valid,
	input wire logic [1:0]                             o_queue_select,
	input wire logic                                   i_mirror_enable,
	input wire logic                                   i_frame_valid,
	input wire switch_queue_vlan_entry_pkg::frame_req_t i_frame,
	input wire logic                                   o_fwd_valid,
	input wire switch_queue_vlan_entry_pkg::fwd_result_t o_fwd,
	input wire switch_queue_vlan_entry_pkg::vlan_entry_t o_entry,
	input wire switch_queue_vlan_entry_pkg::queue_ctrl_t o_queue_ctrl
);
	import switch_queue_vlan_entry_pkg::*;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	function automatic logic [1:0] exp_q(input logic [1:0] c, input logic [1:0] p);
		return {1'b0, (c == 2'h0) ? (p == 2'h3) : ((c == 2'h3) ? (p != 2'h0) : p[1])};
	endfunction
	////////////////////////////////////////////////////////////////
	sequence rd_queue;
		i_reg_rd_en && i_reg_addr == `QUEUE_CTRL_OFFSET;
	endsequence
	sequence rd_entry;
		i_reg_rd_en && i_reg_addr == `VLAN_ENTRY0_OFFSET;
	endsequence
	sequence frame_kept;
		i_frame_valid && o_queue_ctrl.unicast_membership_discard;
	endsequence
	wire use_ovr = o_entry.entry_valid && o_entry.entry_forward_override;
	////////////////////////////////////////////////////////////////
	a_rd_idle_zero: assert property (!i_reg_rd_en |=> o_reg_rd_data == 32'h0)
		else $error("read data not zero outside a read");
	a_queue_readback: assert property (rd_queue |=> o_reg_rd_data == {24'h0, $past(o_queue_ctrl)})
		else $error("queue control readback wrong");
	a_entry_readback: assert property (rd_entry |=> o_reg_rd_data == {$past(o_entry.entry_valid), 3'h0,
		$past(o_entry.entry_forward_override), $past(o_entry.vlan_priority), 9'h0,
		$past(o_entry.spanning_tree_instance), 5'h0, $past(o_entry.filter_identifier)})
		else $error("entry readback wrong");
	a_two_queue_map: assert property (i_queue_req_valid && i_two_queue_mode |=> o_queue_valid &&
		o_queue_select == exp_q($past(o_queue_ctrl.two_queue_priority_map), $past(i_regen_priority)))
		else $error("two queue mapping wrong");
	a_four_queue_pass: assert property (i_queue_req_valid && !i_two_queue_mode |=>
		o_queue_select == $past(i_regen_priority)) else $error("queue select not priority");
	a_port_four_clear: assert property (o_fwd_valid |-> !o_fwd.forward_map[4])
		else $error("reserved port bit set");
	a_ingress_restrict: assert property (frame_kept |=> o_fwd_valid &&
		(o_fwd.forward_map & ~$past(i_frame.ingress_member_map)) == 7'h0) else $error("frame not restricted");
	a_mirror_drop: assert property (i_frame_valid && !o_queue_ctrl.unicast_membership_discard && i_mirror_enable
		&& i_frame.single_destination && i_frame.mirrored |=> o_fwd.dropped && o_fwd.forward_map == 7'h0)
		else $error("mirrored frame not dropped");
	a_override_map: assert property (frame_kept and use_ovr |=> o_fwd.forward_map ==
		($past(i_frame.vlan_forward_map) & $past(i_frame.ingress_member_map) & 7'h6f)) else $error("override map wrong");
	a_other_source: assert property (frame_kept and !use_ovr |=> o_fwd.forward_map ==
		($past(i_frame.other_source_map) & $past(i_frame.ingress_member_map) & 7'h6f)) else $error("other map wrong");
endmodule
bind switch_queue_vlan_entry_regs switch_queue_vlan_entry_regs_monitor mon_u (.i_clock, .i_arst_n, .i_reg_addr,
	.i_reg_rd_en, .o_reg_rd_data, .i_two_queue_mode, .i_queue_req_valid, .i_regen_priority, .o_queue_valid,
	.o_queue_select, .i_mirror_enable, .i_frame_valid, .i_frame, .o_fwd_valid, .o_fwd, .o_entry, .o_queue_ctrl);

// ==== test_switch_queue_vlan_entry_regs.sv ====
// self-checking bench for the queue control and vlan entry register bank
// assumes the monitor is bound to the design by its own file
`timescale 1ns/1ns
`include "switch_queue_vlan_entry_map.svh"
module test_switch_queue_vlan_entry_regs;
	import switch_queue_vlan_entry_pkg::*;
	logic        i_clock = 1'b0, i_arst_n = 1'b0;
	logic [15:0] i_reg_addr = 16'h0;
	logic [31:0] i_reg_wr_data = 32'h0, o_reg_rd_data;
	logic        i_reg_wr_en = 1'b0, i_reg_rd_en = 1'b0, i_two_queue_mode = 1'b0, i_queue_req_valid = 1'b0;
	logic [1:0]  i_regen_priority = 2'h0, o_queue_select;
	logic        o_queue_valid, i_mirror_enable = 1'b0, i_frame_valid = 1'b0, o_fwd_valid;
	frame_req_t  i_frame = '0;
	fwd_result_t o_fwd;
	vlan_entry_t o_entry;
	queue_ctrl_t o_queue_ctrl;
	int          mismatches = 0, cmp_count = 0;
	switch_queue_vlan_entry_regs dut_u (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
		.i_reg_wr_data(i_reg_wr_data), .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en),
		.o_reg_rd_data(o_reg_rd_data), .i_two_queue_mode(i_two_queue_mode), .i_queue_req_valid(i_queue_req_valid),
		.i_regen_priority(i_regen_priority), .o_queue_valid(o_queue_valid), .o_queue_select(o_queue_select),
		.i_mirror_enable(i_mirror_enable), .i_frame_valid(i_frame_valid), .i_frame(i_frame),
		.o_fwd_valid(o_fwd_valid), .o_fwd(o_fwd), .o_entry(o_entry), .o_queue_ctrl(o_queue_ctrl));
	always #10 i_clock = ~i_clock;
	////////////////////////////////////////////////////////////////
	task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
		check_rd({24'h0, got}, {24'h0, exp});
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wr_data <= d;
		i_reg_wr_en <= 1'b1;
		@(posedge i_clock);
		i_reg_wr_en <= 1'b0;
	endtask
	task automatic reg_rd(input logic [15:0] a, input logic [31:0] exp);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_rd_en <= 1'b1;
		@(posedge i_clock);
		i_reg_rd_en <= 1'b0;
		#1 check_rd(o_reg_rd_data, exp);
	endtask
	task automatic qmap(input logic m, input logic [1:0] p, input logic [1:0] e);
		@(posedge i_clock);
		i_two_queue_mode <= m;
		i_regen_priority <= p;
		i_queue_req_valid <= 1'b1;
		@(posedge i_clock);
		i_queue_req_valid <= 1'b0;
		#1 check_out({o_queue_valid, 5'h0, o_queue_select}, {1'b1, 5'h0, e});
	endtask
	task automatic frame(input frame_req_t f, input fwd_result_t e);
		@(posedge i_clock);
		i_frame <= f;
		i_frame_valid <= 1'b1;
		@(posedge i_clock);
		i_frame_valid <= 1'b0;
		#1 check_out({7'h0, o_fwd_valid}, 8'h1);
		check_out(o_fwd, e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check_out(o_queue_ctrl, 8'h82);
		reg_rd(`QUEUE_CTRL_OFFSET, 32'h82);
		reg_rd(`VLAN_ENTRY0_OFFSET, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_regs;
		reg_wr(`VLAN_ENTRY0_OFFSET, 32'hffffffff);
		reg_rd(`VLAN_ENTRY0_OFFSET, 32'h8f00707f);
		reg_wr(`VLAN_ENTRY0_OFFSET, 32'h0a003055);
		reg_rd(`VLAN_ENTRY0_OFFSET, 32'h0a003055);
		check_rd({17'h0, o_entry}, 32'h000029d5);
		reg_wr(`QUEUE_CTRL_OFFSET, 32'hffffffff);
		reg_rd(`QUEUE_CTRL_OFFSET, 32'hff);
		reg_wr(16'h0404, 32'hffffffff);
		reg_rd(16'h0404, 32'h0);
		reg_rd(`QUEUE_CTRL_OFFSET, 32'hff);
		$display("test registers done");
	endtask
	task automatic t_qmap;
		logic [1:0] c, p;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			reg_wr(`QUEUE_CTRL_OFFSET, {24'h0, c, 6'h2});
			for (int j = 0; j < 4; j++) begin
				p = 2'(j);
				qmap(1'b1, p, {1'b0, (c == 2'h0) ? (p == 2'h3) : ((c == 2'h3) ? (p != 2'h0) : p[1])});
				qmap(1'b0, p, p);
			end
		end
		$display("test queue map done");
	endtask
	task automatic t_fwd;
		reg_wr(`QUEUE_CTRL_OFFSET, 32'h82);
		reg_wr(`VLAN_ENTRY0_OFFSET, 32'h88000000);
		frame('{7'h3c, 7'h01, 7'h7f, 1'b1, 1'b0}, '{7'h2c, 1'b0});
		reg_wr(`VLAN_ENTRY0_OFFSET, 32'h80000000);
		frame('{7'h0f, 7'h55, 7'h7f, 1'b0, 1'b0}, '{7'h05, 1'b0});
		reg_wr(`QUEUE_CTRL_OFFSET, 32'h80);
		i_mirror_enable <= 1'b1;
		frame('{7'h01, 7'h7f, 7'h00, 1'b1, 1'b0}, '{7'h6f, 1'b0});
		frame('{7'h01, 7'h7f, 7'h00, 1'b1, 1'b1}, '{7'h00, 1'b1});
		frame('{7'h03, 7'h7f, 7'h00, 1'b0, 1'b1}, '{7'h03, 1'b0});
		@(posedge i_clock);
		i_mirror_enable <= 1'b0;
		frame('{7'h01, 7'h7f, 7'h00, 1'b1, 1'b1}, '{7'h6f, 1'b0});
		$display("test forwarding done");
	endtask
	////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		final_report();
	end
	initial begin
		repeat (6) @(posedge i_clock);
		i_arst_n <= 1'b1;
		t_reset();
		t_regs();
		t_qmap();
		t_fwd();
		final_report();
	end
endmodule
